/* File: core/ldcb_params.svh */
// Constants for the logical device configuration bank
`ifndef LDCB_PARAMS_SVH
`define LDCB_PARAMS_SVH
// Register indices
`define LDCB_IDX_ACT      8'h30
`define LDCB_IDX_B0H      8'h60
`define LDCB_IDX_B0L      8'h61
`define LDCB_IDX_B1H      8'h62
`define LDCB_IDX_B1L      8'h63
`define LDCB_IDX_IRQ0     8'h70
`define LDCB_IDX_IRQ1     8'h72
`define LDCB_IDX_DMA      8'h74
// Field positions
`define LDCB_ACT_BIT      0
`define LDCB_IRQ_MSB      3
`define LDCB_DMA_MSB      2
`define LDCB_DMA_LAST     3'h3
// Reset values
`define LDCB_RST_ZERO     8'h00
`define LDCB_IRQ0_RST_LD0 8'h06
`define LDCB_DMA_RST_LD0  8'h02
`define LDCB_DMA_RST_ALT  8'h04
// Bank numbers
`define LDCB_LD_FLOPPY    3'h0
`define LDCB_LD_PARALLEL  3'h1
`define LDCB_LD_DMA_ALT   3'h4
`define LDCB_LD_KEYBOARD  3'h7
// Allowed base range and alignment masks
`define LDCB_BASE_MIN     16'h0100
`define LDCB_BASE_MAX     16'h0ff8
// Parallel port may sit on four byte steps up to here
`define LDCB_BASE_MAX4    16'h0ffc
`define LDCB_ALIGN8       16'h0007
`define LDCB_ALIGN4       16'h0003
`endif

/* File: core/ldcb_pkg.sv */
// Types and shared functions of the logical device configuration bank
`include "ldcb_params.svh"
package ldcb_pkg;
  // Storage slot inside one bank
  typedef enum logic [2:0] {
    SL_ACT  = 3'h0,
    SL_B0H  = 3'h1,
    SL_B0L  = 3'h2,
    SL_B1H  = 3'h3,
    SL_B1L  = 3'h4,
    SL_IRQ0 = 3'h5,
    SL_IRQ1 = 3'h6,
    SL_DMA  = 3'h7
  } ldcb_slot_type;

  // Decoded index
  typedef struct packed {
    logic          hit;
    ldcb_slot_type slot;
  } ldcb_dec_type;

  // Host access through index and data ports
  typedef struct packed {
    logic       idx_wr;
    logic       data_wr;
    logic       data_rd;
    logic [7:0] wdata;
  } ldcb_host_type;

  // Per-device view handed to the logical devices
  typedef struct packed {
    logic        on;
    logic        io_ok;
    logic        edge_high;
    logic [3:0]  irq_num;
    logic [1:0]  dma_num;
    logic [15:0] base;
    logic [15:0] base2;
  } ldcb_dev_type;

  // Index to slot; everything else is unmapped
  function automatic ldcb_dec_type decode(input logic [7:0] idx);
    ldcb_dec_type d;
    d = '{hit: 1'b1, slot: SL_ACT};
    case (idx)
      `LDCB_IDX_ACT:  d.slot = SL_ACT;
      `LDCB_IDX_B0H:  d.slot = SL_B0H;
      `LDCB_IDX_B0L:  d.slot = SL_B0L;
      `LDCB_IDX_B1H:  d.slot = SL_B1H;
      `LDCB_IDX_B1L:  d.slot = SL_B1L;
      `LDCB_IDX_IRQ0: d.slot = SL_IRQ0;
      `LDCB_IDX_IRQ1: d.slot = SL_IRQ1;
      `LDCB_IDX_DMA:  d.slot = SL_DMA;
      default:        d.hit = 1'b0;
    endcase
    return d;
  endfunction

  // Default contents of each slot of each bank
  function automatic logic [7:0] reset_val(input logic [2:0] bank,
                                           input logic [2:0] slot);
    logic [7:0] v;
    v = `LDCB_RST_ZERO;
    if (slot == SL_IRQ0 && bank == `LDCB_LD_FLOPPY) begin
      v = `LDCB_IRQ0_RST_LD0;
    end
    if (slot == SL_DMA && bank == `LDCB_LD_FLOPPY) begin
      v = `LDCB_DMA_RST_LD0;
    end
    if (slot == SL_DMA && bank == `LDCB_LD_DMA_ALT) begin
      v = `LDCB_DMA_RST_ALT;
    end
    return v;
  endfunction
endpackage

/* File: core/ldcb_bank_mem.sv */
// Bank storage: one byte per slot per logical device
module ldcb_bank_mem #(
  parameter int NLD = 8
) (
  // Clock and reset
  input  wire logic                 clock,
  input  wire logic                 nrst,
  // Load defaults
  input  wire logic                 clear,
  // Write port
  input  wire logic                 wr_en,
  input  wire logic [5:0]           wr_addr,
  input  wire logic [7:0]           wr_data,
  // Read port
  input  wire logic [5:0]           rd_addr,
  output logic      [7:0]           rd_data_q,
  // Whole contents for the device outputs
  output logic      [NLD*64-1:0]    all_q
);
  // Storage array
  logic [7:0] mem_q [NLD*8];

  // Defaults on reset and clear, else single write
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < NLD*8; i++) begin
        mem_q[i] <= ldcb_pkg::reset_val(3'(i >> 3), 3'(i));
      end
    end else if (clear) begin
      for (int i = 0; i < NLD*8; i++) begin
        mem_q[i] <= ldcb_pkg::reset_val(3'(i >> 3), 3'(i));
      end
    end else if (wr_en) begin
      mem_q[wr_addr] <= wr_data;
    end
  end

  // Registered read data
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rd_data_q <= 8'h00;
    end else begin
      rd_data_q <= mem_q[rd_addr];
    end
  end

  // Flattened view
  always_comb begin
    for (int i = 0; i < NLD*8; i++) begin
      all_q[i*8 +: 8] = mem_q[i];
    end
  end
endmodule

/* File: core/ldcb_bank.sv */
// Per-logical-device configuration register bank
`include "ldcb_params.svh"
module ldcb_bank #(
  parameter int NLD = 8
) (
  // Clock and reset
  input  wire logic                          clock,
  input  wire logic                          nrst,
  // Other resets
  input  wire logic                          standby_supply_power_on_reset,
  input  wire logic                          hard_reset,
  input  wire logic                          soft_reset,
  // Configuration state and chosen bank
  input  wire logic                          cfg_mode,
  input  wire logic [7:0]                    ld_sel,
  // Host index and data ports
  input  wire ldcb_pkg::ldcb_host_type       host,
  output logic      [7:0]                    rdata,
  output logic                               rd_valid_q,
  // Power-control bit writes
  input  wire logic                          pwr_wr,
  input  wire logic [2:0]                    pwr_bank,
  input  wire logic                          pwr_val,
  // Parallel port extended modes
  input  wire logic                          ecp_epp_mode,
  // Device interrupt requests and enables
  input  wire logic [NLD-1:0]                dev_irq_req,
  input  wire logic [NLD-1:0]                dev_irq_en,
  // Device view and routed interrupt lines
  output ldcb_pkg::ldcb_dev_type [NLD-1:0]   dev_q,
  output logic      [15:0]                   irq_lines_q
);
  // Standby reset pin synchroniser
  logic sb_meta_q;
  logic sb_sync_q;
  // Index register
  logic [7:0] index_q;
  // Decoded access
  ldcb_pkg::ldcb_dec_type dec;
  logic       bank_ok;
  logic       impl;
  logic       acc_ok;
  logic       clear;
  // Memory ports
  logic       cfg_we;
  logic       mem_we;
  logic [2:0] wr_bank;
  logic [2:0] wr_slot;
  logic [7:0] wr_data;
  logic [7:0] mem_rd;
  logic       rd_hit_q;
  logic [NLD*64-1:0] all_q;
  // Helper vectors
  logic [NLD-1:0] on_vec;
  logic [NLD-1:0] ok_vec;
  logic [NLD-1:0] edge_vec;

  // Slot present in this bank
  function automatic logic implemented(input logic [2:0] bank,
                                       input logic [2:0] slot);
    logic r;
    r = 1'b0;
    case (slot)
      // Present everywhere
      ldcb_pkg::SL_ACT, ldcb_pkg::SL_B0H,
      ldcb_pkg::SL_B0L, ldcb_pkg::SL_IRQ0: begin
        r = 1'b1;
      end
      // Second base and secondary select in keyboard only
      ldcb_pkg::SL_B1H, ldcb_pkg::SL_B1L,
      ldcb_pkg::SL_IRQ1: begin
        r = (bank == `LDCB_LD_KEYBOARD);
      end
      // DMA select in DMA capable banks
      ldcb_pkg::SL_DMA: begin
        r = (bank == `LDCB_LD_FLOPPY) || (bank == `LDCB_LD_PARALLEL)
            || (bank == `LDCB_LD_DMA_ALT);
      end
      default: begin
        r = 1'b0;
      end
    endcase
    return r;
  endfunction

  // Base inside allowed range and aligned
  function automatic logic base_ok(input logic [2:0] bank,
                                   input logic [15:0] base);
    logic [15:0] m;
    logic [15:0] top;
    // Parallel port allows finer steps and a higher top
    m   = (bank == `LDCB_LD_PARALLEL) ? `LDCB_ALIGN4 : `LDCB_ALIGN8;
    top = (bank == `LDCB_LD_PARALLEL) ? `LDCB_BASE_MAX4 : `LDCB_BASE_MAX;
    return (base >= `LDCB_BASE_MIN) && (base <= top)
           && ((base & m) == 16'h0000);
  endfunction

  // Two flops before the standby reset is used
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      sb_meta_q <= 1'b0;
      sb_sync_q <= 1'b0;
    end else begin
      sb_meta_q <= standby_supply_power_on_reset;
      sb_sync_q <= sb_meta_q;
    end
  end

  // Every reset source reloads the defaults
  assign clear = sb_sync_q | hard_reset | soft_reset;

  // Index port, taken only in configuration state
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      index_q <= 8'h00;
    end else if (host.idx_wr && cfg_mode) begin
      index_q <= host.wdata;
    end
  end

  // Access decode for the data port
  always_comb begin
    dec     = ldcb_pkg::decode(index_q);
    bank_ok = (ld_sel < 8'(NLD));
    impl    = implemented(ld_sel[2:0], dec.slot);
    acc_ok  = cfg_mode && bank_ok && dec.hit && impl;
  end

  // Host writes win over power-control writes
  assign cfg_we = host.data_wr && acc_ok && !clear;

  // Memory write mux
  always_comb begin
    mem_we  = 1'b0;
    wr_bank = ld_sel[2:0];
    wr_slot = dec.slot;
    wr_data = host.wdata;
    if (cfg_we) begin
      // Data port write into the chosen bank
      mem_we = 1'b1;
      if (dec.slot == ldcb_pkg::SL_ACT) begin
        // Keep only the activate bit
        wr_data = {7'h00, host.wdata[`LDCB_ACT_BIT]};
      end
    end else if (pwr_wr && !clear && (32'(pwr_bank) < NLD)) begin
      // Power bit mirrored into activate
      mem_we  = 1'b1;
      wr_bank = pwr_bank;
      wr_slot = ldcb_pkg::SL_ACT;
      wr_data = {7'h00, pwr_val};
    end
  end

  // Bank storage
  ldcb_bank_mem #(
    .NLD (NLD)
  ) u_mem (
    .clock     (clock),
    .nrst      (nrst),
    .clear     (clear),
    .wr_en     (mem_we),
    .wr_addr   ({wr_bank, wr_slot}),
    .wr_data   (wr_data),
    .rd_addr   ({ld_sel[2:0], dec.slot}),
    .rd_data_q (mem_rd),
    .all_q     (all_q)
  );

  // Read answer follows one cycle after the strobe
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rd_valid_q <= 1'b0;
      rd_hit_q   <= 1'b0;
    end else begin
      rd_valid_q <= host.data_rd;
      rd_hit_q   <= host.data_rd && acc_ok;
    end
  end

  // Unmapped, absent or out of state reads give zero
  assign rdata = rd_hit_q ? mem_rd : 8'h00;

  // Device view, one bank each
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      dev_q <= '0;
    end else begin
      for (int b = 0; b < NLD; b++) begin
        // Activate and power bit are one stored bit
        dev_q[b].on <= all_q[b*64 + `LDCB_ACT_BIT];
        // First and second base
        dev_q[b].base  <= {all_q[b*64+8 +: 8], all_q[b*64+16 +: 8]};
        dev_q[b].base2 <= {all_q[b*64+24 +: 8], all_q[b*64+32 +: 8]};
        // Host decode allowed only with a legal base
        dev_q[b].io_ok <= all_q[b*64 + `LDCB_ACT_BIT]
          && base_ok(3'(b), {all_q[b*64+8 +: 8], all_q[b*64+16 +: 8]});
        // Interrupt line number
        dev_q[b].irq_num <= all_q[b*64+40 +: 4];
        // Parallel port in extended modes is not edge high
        dev_q[b].edge_high <= !((3'(b) == `LDCB_LD_PARALLEL)
                                && ecp_epp_mode);
        // Channel 1..3 or none
        if (all_q[b*64+56 +: 3] != 3'h0
            && all_q[b*64+56 +: 3] <= `LDCB_DMA_LAST) begin
          dev_q[b].dma_num <= all_q[b*64+56 +: 2];
        end else begin
          dev_q[b].dma_num <= 2'h0;
        end
      end
    end
  end

  // Interrupt routing onto numbered lines
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      irq_lines_q <= 16'h0000;
    end else begin
      for (int n = 0; n < 16; n++) begin
        irq_lines_q[n] <= 1'b0;
        for (int b = 0; b < NLD; b++) begin
          // Line zero means no interrupt
          if (n != 0 && dev_q[b].irq_num == 4'(n) && dev_q[b].on
              && dev_irq_en[b] && dev_irq_req[b]) begin
            irq_lines_q[n] <= 1'b1;
          end
        end
      end
    end
  end

  // Helper vectors for checks
  always_comb begin
    for (int b = 0; b < NLD; b++) begin
      on_vec[b]   = dev_q[b].on;
      ok_vec[b]   = dev_q[b].io_ok;
      edge_vec[b] = dev_q[b].edge_high;
    end
  end

  // Outside configuration state reads return zero
  AST_READ_OUTSIDE_CFG: assert property (
    @(posedge clock) disable iff (!nrst)
    host.data_rd && !cfg_mode |=> rd_valid_q && rdata == 8'h00
  ) else $error("read outside configuration state not zero");

  // Reserved and absent registers read zero
  AST_UNMAPPED_ZERO: assert property (
    @(posedge clock) disable iff (!nrst)
    host.data_rd && !(dec.hit && impl) |=> rdata == 8'h00
  ) else $error("unmapped index returned data");

  // Activate reserved bits never read back
  AST_ACT_RESERVED: assert property (
    @(posedge clock) disable iff (!nrst)
    host.data_rd && dec.slot == ldcb_pkg::SL_ACT |=> rdata[7:1] == 7'h00
  ) else $error("activate reserved bits read nonzero");

  // Power bit write mirrors into device on state
  AST_POWER_MIRROR: assert property (
    @(posedge clock) disable iff (!nrst)
    pwr_wr && !cfg_we && !clear && 32'(pwr_bank) < NLD
      ##1 !mem_we && !clear |=> on_vec[$past(pwr_bank, 2)] == $past(pwr_val, 2)
  ) else $error("power bit not mirrored in activate");

  // High base byte written reaches the device view
  AST_BASE_WRITE: assert property (
    @(posedge clock) disable iff (!nrst)
    cfg_we && dec.slot == ldcb_pkg::SL_B0H ##1 !mem_we && !clear
      |=> dev_q[$past(wr_bank, 2)].base[15:8] == $past(host.wdata, 2)
  ) else $error("base high byte not stored");

  // Defaults after a soft or hard reset
  AST_RESET_DEFAULTS: assert property (
    @(posedge clock) disable iff (!nrst)
    clear ##1 !mem_we && !clear |=> !dev_q[0].on && dev_q[0].base == 16'h0000
  ) else $error("activate or base not cleared");

  // Primary select default in bank zero
  AST_IRQ_DEFAULT: assert property (
    @(posedge clock) disable iff (!nrst)
    clear ##1 !mem_we && !clear |=> dev_q[0].irq_num == 4'h6
  ) else $error("bank zero interrupt default wrong");

  // DMA default in bank zero
  AST_DMA_DEFAULT: assert property (
    @(posedge clock) disable iff (!nrst)
    clear ##1 !mem_we && !clear |=> dev_q[0].dma_num == 2'h2
  ) else $error("bank zero dma default wrong");

  // Line zero never driven, lines need an enable
  AST_IRQ_NEEDS_EN: assert property (
    @(posedge clock) disable iff (!nrst)
    irq_lines_q != 16'h0000 |-> !irq_lines_q[0]
      && $past(|(dev_irq_en & dev_irq_req & on_vec))
  ) else $error("interrupt driven without enable");

  // Legal base decode needs an active device
  AST_IO_NEEDS_ON: assert property (
    @(posedge clock) disable iff (!nrst)
    (ok_vec & ~on_vec) == '0
  ) else $error("host decode enabled on inactive device");

  // Edge high outside extended parallel modes
  AST_EDGE_HIGH: assert property (
    @(posedge clock) disable iff (!nrst)
    nrst && !ecp_epp_mode |=> &edge_vec
  ) else $error("interrupt type not edge high");
endmodule

/* File: tb/tb_top.sv */
// Self-checking bench for the logical device configuration bank
`include "ldcb_params.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  // Clock, resets and mode inputs
  logic                            clock;
  logic                            nrst;
  logic                            standby_supply_power_on_reset;
  logic                            hard_reset;
  logic                            soft_reset;
  logic                            cfg_mode;
  logic [7:0]                      ld_sel;
  // Host ports and answers
  ldcb_pkg::ldcb_host_type         host;
  logic [7:0]                      rdata;
  logic                            rd_valid_q;
  // Power-control side and device side
  logic                            pwr_wr;
  logic [2:0]                      pwr_bank;
  logic                            pwr_val;
  logic                            ecp_epp_mode;
  logic [7:0]                      dev_irq_req;
  logic [7:0]                      dev_irq_en;
  ldcb_pkg::ldcb_dev_type [7:0]    dev_q;
  logic [15:0]                     irq_lines_q;
  // Counters
  int                              n_errors;
  int                              n_tests;

  // Design under test
  ldcb_bank #(.NLD(8)) ldcb_bank_inst (
    .clock                         (clock),
    .nrst                          (nrst),
    .standby_supply_power_on_reset (standby_supply_power_on_reset),
    .hard_reset                    (hard_reset),
    .soft_reset                    (soft_reset),
    .cfg_mode                      (cfg_mode),
    .ld_sel                        (ld_sel),
    .host                          (host),
    .rdata                         (rdata),
    .rd_valid_q                    (rd_valid_q),
    .pwr_wr                        (pwr_wr),
    .pwr_bank                      (pwr_bank),
    .pwr_val                       (pwr_val),
    .ecp_epp_mode                  (ecp_epp_mode),
    .dev_irq_req                   (dev_irq_req),
    .dev_irq_en                    (dev_irq_en),
    .dev_q                         (dev_q),
    .irq_lines_q                   (irq_lines_q)
  );

  // Free-running 200 MHz clock
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  // Verdict and end of run
  task automatic report_and_stop();
    if (n_errors == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Compare any design value, widened to 16 bits
  task automatic compare(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Let n edges pass, then settle
  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  // Index write then data write, in the chosen bank
  task automatic put(input logic [7:0] ld, input logic [7:0] idx, input logic [7:0] val);
    @(posedge clock);
    ld_sel <= ld;
    host.idx_wr <= 1'b1;
    host.wdata <= idx;
    @(posedge clock);
    host.idx_wr <= 1'b0;
    host.data_wr <= 1'b1;
    host.wdata <= val;
    @(posedge clock);
    host.data_wr <= 1'b0;
  endtask

  // Index write then data read; answer one cycle later
  task automatic expect_reg(input logic [7:0] ld, input logic [7:0] idx, input logic [7:0] exp);
    @(posedge clock);
    ld_sel <= ld;
    host.idx_wr <= 1'b1;
    host.wdata <= idx;
    @(posedge clock);
    host.idx_wr <= 1'b0;
    host.data_rd <= 1'b1;
    @(posedge clock);
    host.data_rd <= 1'b0;
    #1;
    compare(rd_valid_q, 1'b1);
    compare(rdata, exp);
  endtask

  // Defaults after power-on
  task automatic t_defaults();
    expect_reg(8'h00, 8'h70, 8'h06);
    expect_reg(8'h03, 8'h70, 8'h00);
    expect_reg(8'h00, 8'h74, 8'h02);
    expect_reg(8'h04, 8'h74, 8'h04);
    expect_reg(8'h02, 8'h30, 8'h00);
    expect_reg(8'h02, 8'h61, 8'h00);
    compare(dev_q[0].irq_num, 16'h0006);
    compare(dev_q[0].dma_num, 16'h0002);
  endtask

  // Base pairs, separate banks, second base only in bank 7
  task automatic t_bases();
    put(8'h02, 8'h60, 8'h03);
    put(8'h02, 8'h61, 8'hf8);
    put(8'h03, 8'h60, 8'h05);
    put(8'h07, 8'h62, 8'h0a);
    put(8'h07, 8'h63, 8'h10);
    put(8'h02, 8'h62, 8'h0c);
    step(3);
    compare(dev_q[2].base, 16'h03f8);
    compare(dev_q[3].base, 16'h0500);
    compare(dev_q[7].base2, 16'h0a10);
    expect_reg(8'h02, 8'h60, 8'h03);
    expect_reg(8'h03, 8'h60, 8'h05);
    expect_reg(8'h02, 8'h62, 8'h00);
    expect_reg(8'h07, 8'h63, 8'h10);
  endtask

  // Reserved indices ignore writes and read zero
  task automatic t_reserved();
    logic [7:0] idx [12];
    idx = '{8'h31, 8'h37, 8'h38, 8'h40, 8'h5f, 8'h64, 8'h71, 8'h73, 8'h75, 8'h76, 8'ha8, 8'hdf};
    foreach (idx[i]) begin
      put(8'h01, idx[i], 8'hff);
      expect_reg(8'h01, idx[i], 8'h00);
    end
    // A bank number past the last bank reaches nothing
    put(8'h08, 8'h30, 8'h01);
    expect_reg(8'h08, 8'h30, 8'h00);
  endtask

  // Activate bit, reserved bits, power-control link, valid range
  task automatic t_activate();
    put(8'h02, 8'h30, 8'hff);
    step(3);
    expect_reg(8'h02, 8'h30, 8'h01);
    compare(dev_q[2].on, 1'b1);
    compare(dev_q[2].io_ok, 1'b1);
    @(posedge clock);
    pwr_wr <= 1'b1;
    pwr_bank <= 3'h2;
    pwr_val <= 1'b0;
    @(posedge clock);
    pwr_wr <= 1'b0;
    step(3);
    compare(dev_q[2].on, 1'b0);
    expect_reg(8'h02, 8'h30, 8'h00);
    @(posedge clock);
    pwr_wr <= 1'b1;
    pwr_val <= 1'b1;
    @(posedge clock);
    pwr_wr <= 1'b0;
    expect_reg(8'h02, 8'h30, 8'h01);
    put(8'h02, 8'h60, 8'h00);
    put(8'h02, 8'h61, 8'h50);
    step(3);
    compare(dev_q[2].io_ok, 1'b0);
    put(8'h02, 8'h60, 8'h03);
    put(8'h02, 8'h61, 8'hf8);
    // Parallel port base on a four byte step at the top of its range
    put(8'h01, 8'h30, 8'h01);
    put(8'h01, 8'h60, 8'h0f);
    put(8'h01, 8'h61, 8'hfc);
    step(3);
    compare(dev_q[1].io_ok, 1'b1);
  endtask

  // Outside configuration state no host write reaches the bank
  task automatic t_cfg_off();
    @(posedge clock);
    cfg_mode <= 1'b0;
    put(8'h02, 8'h61, 8'h20);
    expect_reg(8'h02, 8'h61, 8'h00);
    @(posedge clock);
    cfg_mode <= 1'b1;
    expect_reg(8'h02, 8'h61, 8'hf8);
  endtask

  // Every primary line code, enable gating, edge type
  task automatic t_irq();
    @(posedge clock);
    dev_irq_req <= 8'h04;
    dev_irq_en <= 8'h04;
    for (int n = 0; n < 16; n++) begin
      put(8'h02, 8'h70, 8'(n));
      step(4);
      compare(dev_q[2].irq_num, 16'(n));
      compare(irq_lines_q, (n == 0) ? 16'h0000 : (16'h0001 << n));
    end
    @(posedge clock);
    dev_irq_en <= 8'h00;
    step(4);
    compare(irq_lines_q, 16'h0000);
    compare(dev_q[2].edge_high, 1'b1);
    @(posedge clock);
    ecp_epp_mode <= 1'b1;
    step(3);
    compare(dev_q[1].edge_high, 1'b0);
    compare(dev_q[2].edge_high, 1'b1);
  endtask

  // Secondary interrupt and DMA selects
  task automatic t_sel();
    put(8'h07, 8'h72, 8'h0a);
    put(8'h03, 8'h72, 8'h0a);
    expect_reg(8'h07, 8'h72, 8'h0a);
    expect_reg(8'h03, 8'h72, 8'h00);
    put(8'h02, 8'h74, 8'h03);
    expect_reg(8'h02, 8'h74, 8'h00);
    for (int v = 0; v < 8; v++) begin
      put(8'h01, 8'h74, 8'(v));
      step(3);
      compare(dev_q[1].dma_num, (v >= 1 && v <= 3) ? 16'(v) : 16'h0000);
    end
    expect_reg(8'h01, 8'h74, 8'h07);
  endtask

  // Standby, hard and soft reset reload defaults
  task automatic t_resets();
    for (int k = 0; k < 3; k++) begin
      put(8'h02, 8'h30, 8'h01);
      put(8'h00, 8'h70, 8'h09);
      @(posedge clock);
      standby_supply_power_on_reset <= (k == 0);
      hard_reset <= (k == 1);
      soft_reset <= (k == 2);
      repeat (5) @(posedge clock);
      standby_supply_power_on_reset <= 1'b0;
      hard_reset <= 1'b0;
      soft_reset <= 1'b0;
      step(3);
      expect_reg(8'h02, 8'h30, 8'h00);
      expect_reg(8'h02, 8'h60, 8'h00);
      expect_reg(8'h00, 8'h70, 8'h06);
    end
  endtask

  // Watchdog against a hang
  initial begin
    repeat (20000) @(posedge clock);
    n_errors++;
    report_and_stop();
  end

  // Main sequence
  initial begin
    n_errors = 0;
    n_tests = 0;
    nrst = 1'b0;
    standby_supply_power_on_reset = 1'b0;
    hard_reset = 1'b0;
    soft_reset = 1'b0;
    cfg_mode = 1'b1;
    ld_sel = 8'h00;
    host = '0;
    pwr_wr = 1'b0;
    pwr_bank = 3'h0;
    pwr_val = 1'b0;
    ecp_epp_mode = 1'b0;
    dev_irq_req = 8'h00;
    dev_irq_en = 8'h00;
    repeat (10) @(posedge clock);
    nrst <= 1'b1;
    step(2);
    t_defaults();
    t_bases();
    t_reserved();
    t_activate();
    t_cfg_off();
    t_irq();
    t_sel();
    t_resets();
    report_and_stop();
  end
endmodule
